// ===== adc_capture_fifo_clocking.sv
// Two-channel converter capture with FIFO clock generation and return check
//
// Functional notes
// RL1: FIFO clock outputs run continuously, never gated.
// RL2: Carrier FIFO clock phase matches returned copies.
// RL3: Output FIFO clock returns on its global input.
// RL4: Input FIFO clock returns on its global input.
// RL5: Interface logic clocked by its own interface clock.
// RL6: Twelve-bit two's complement samples per channel.
// RL7: Over-range flag accompanies saturated samples.
// RL8: Encode clock not above converter maximum rate.
// RL9: Encode clock preferably above lower sample rate.
// RL10: Thirteen encode cycles total sample latency.
// RL11: Converter pins captured in encode-clocked pad registers.
// RL12: Stream one valid word per encode cycle.
`timescale 1ns/10ps
module adc_capture_fifo_clocking #(
  parameter int WIDTH = adc_capture_pkg::SAMPLE_WIDTH,
  parameter int FIFO_HALF = adc_capture_pkg::FIFO_CLK_HALF
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             encodeClk,
  input  wire logic [WIDTH-1:0] padSampleA,
  input  wire logic             padOverRangeA,
  input  wire logic [WIDTH-1:0] padSampleB,
  input  wire logic             padOverRangeB,
  output logic                  encodeOutA,
  output logic                  encodeOutB,
  output logic      [WIDTH-1:0] sampleA,
  output logic                  overRangeA,
  output logic                  sampleValidA,
  output logic      [WIDTH-1:0] sampleB,
  output logic                  overRangeB,
  output logic                  sampleValidB,
  output logic                  positiveLimitA,
  output logic                  negativeLimitA,
  output logic                  positiveLimitB,
  output logic                  negativeLimitB,
  output logic                  inputFifoClock,
  output logic                  outputFifoClock,
  input  wire logic             inputFifoClockReturn,
  input  wire logic             outputFifoClockReturn,
  output logic                  inputReturnAligned,
  output logic                  outputReturnAligned,
  input  wire logic             clearOverRange,
  output logic                  overRangeSeenA,
  output logic                  overRangeSeenB
);
  logic [7:0]  halfCount;
  logic        fifoClk;
  logic        fifoClkDly1;
  logic        fifoClkDly2;
  logic [1:0]  inRetSync;
  logic [1:0]  outRetSync;
  logic [1:0]  encRstSync;
  logic        encodeRstn;
  logic        togA;
  logic        togB;
  logic [2:0]  togSyncA;
  logic [2:0]  togSyncB;
  wire         halfDone;
  wire         eventA;
  wire         eventB;

  initial begin
    if (WIDTH != 12) $error("adc_capture_fifo_clocking supports 12-bit samples only");
    if (FIFO_HALF < 1 || FIFO_HALF > 255) $error("FIFO_HALF must lie in 1..255");
  end

  // Encode clocks forwarded from the encode domain; rate set by its source
  assign encodeOutA = encodeClk; // RL5
  assign encodeOutB = encodeClk; // RL5

  // Reset carried into the encode domain through two flip-flops
  always_ff @(posedge encodeClk) begin
    encRstSync <= {encRstSync[0], rstn};
  end
  assign encodeRstn = encRstSync[1];

  // Channel A capture, entirely on the encode clock
  adc_channel_capture #(.WIDTH(WIDTH)) chanA (
    .encodeClk       (encodeClk),
    .encodeRstn      (encodeRstn),
    .padSample       (padSampleA),
    .padOverRange    (padOverRangeA),
    .sample          (sampleA),
    .overRange       (overRangeA),
    .sampleValid     (sampleValidA),
    .atPositiveLimit (positiveLimitA),
    .atNegativeLimit (negativeLimitA),
    .overRangeToggle (togA)
  ); // RL5

  // Channel B capture, entirely on the encode clock
  adc_channel_capture #(.WIDTH(WIDTH)) chanB (
    .encodeClk       (encodeClk),
    .encodeRstn      (encodeRstn),
    .padSample       (padSampleB),
    .padOverRange    (padOverRangeB),
    .sample          (sampleB),
    .overRange       (overRangeB),
    .sampleValid     (sampleValidB),
    .atPositiveLimit (positiveLimitB),
    .atNegativeLimit (negativeLimitB),
    .overRangeToggle (togB)
  ); // RL5

  // Free-running FIFO clock divider, never stopped after reset
  assign halfDone = (halfCount == 8'(FIFO_HALF - 1));
  always_ff @(posedge clk) begin
    if (!rstn) begin
      halfCount <= adc_capture_pkg::HALF_RESET;
      fifoClk   <= 1'b0;
    end else if (halfDone) begin
      halfCount <= adc_capture_pkg::HALF_RESET;
      fifoClk   <= ~fifoClk; // RL1
    end else begin
      halfCount <= halfCount + 8'h01;
    end
  end

  // Same clock drives both carrier FIFO clock pins
  assign inputFifoClock  = fifoClk; // RL1
  assign outputFifoClock = fifoClk; // RL1

  // Returned FIFO clocks synchronised, compared to the driven level
  always_ff @(posedge clk) begin
    inRetSync   <= {inRetSync[0], inputFifoClockReturn}; // RL4
    outRetSync  <= {outRetSync[0], outputFifoClockReturn}; // RL3
    fifoClkDly1 <= fifoClk;
    fifoClkDly2 <= fifoClkDly1;
  end

  // Alignment flags: return copy tracks the driven clock
  always_ff @(posedge clk) begin
    if (!rstn) begin
      inputReturnAligned  <= 1'b0;
      outputReturnAligned <= 1'b0;
    end else begin
      inputReturnAligned  <= (inRetSync[1] == fifoClkDly2); // RL2
      outputReturnAligned <= (outRetSync[1] == fifoClkDly2); // RL2
    end
  end

  // Over-range toggles crossed into clk; third stage only feeds the edge detect
  always_ff @(posedge clk) begin
    if (!rstn) begin
      togSyncA <= 3'h0;
      togSyncB <= 3'h0;
    end else begin
      togSyncA <= {togSyncA[1:0], togA};
      togSyncB <= {togSyncB[1:0], togB};
    end
  end
  assign eventA = togSyncA[2] ^ togSyncA[1];
  assign eventB = togSyncB[2] ^ togSyncB[1];

  // Sticky over-range indications; a new event wins over the clear
  always_ff @(posedge clk) begin
    if (!rstn) begin
      overRangeSeenA <= 1'b0;
      overRangeSeenB <= 1'b0;
    end else begin
      overRangeSeenA <= eventA | (overRangeSeenA & ~clearOverRange); // RL7
      overRangeSeenB <= eventB | (overRangeSeenB & ~clearOverRange); // RL7
    end
  end
endmodule

// ===== adc_capture_pkg.sv
// Constants shared by the converter capture and FIFO clocking logic
package adc_capture_pkg;
  localparam int          SAMPLE_WIDTH      = 12;
  localparam int          CHANNELS          = 2;
  localparam int          CONVERTER_LATENCY = 12;
  localparam int          CAPTURE_LATENCY   = 1;
  localparam int          TOTAL_LATENCY     = CONVERTER_LATENCY + CAPTURE_LATENCY;
  localparam logic [11:0] CODE_ZERO         = 12'h000;
  localparam logic [11:0] CODE_FULL_POS     = 12'h7FF;
  localparam logic [11:0] CODE_FULL_NEG     = 12'h800;
  localparam logic [4:0]  FILL_RESET        = 5'h00;
  localparam int          FIFO_CLK_HALF     = 1;
  localparam logic [7:0]  HALF_RESET        = 8'h00;
endpackage

// ===== adc_channel_capture.sv
// One converter channel: pad capture, pipeline fill tracking, word stream
`timescale 1ns/10ps
module adc_channel_capture #(
  parameter int WIDTH = adc_capture_pkg::SAMPLE_WIDTH
) (
  input  wire logic             encodeClk,
  input  wire logic             encodeRstn,
  input  wire logic [WIDTH-1:0] padSample,
  input  wire logic             padOverRange,
  output logic      [WIDTH-1:0] sample,
  output logic                  overRange,
  output logic                  sampleValid,
  output logic                  atPositiveLimit,
  output logic                  atNegativeLimit,
  output logic                  overRangeToggle
);
  logic [WIDTH-1:0] padReg;
  logic             padOvr;
  logic             ovrPrev;
  wire              ovrOnset;
  logic [4:0]       fillCount;
  wire              pipelineFull;
  wire              posLimit;
  wire              negLimit;

  initial begin
    if (WIDTH != 12) $error("adc_channel_capture supports 12-bit samples only");
  end

  // Pad register on the encode clock, one extra stage of latency
  always_ff @(posedge encodeClk) begin
    padReg <= padSample; // RL11
    padOvr <= padOverRange; // RL11
  end

  // Fill counter: words valid once the whole pipeline holds real samples
  assign pipelineFull = (fillCount == 5'(adc_capture_pkg::TOTAL_LATENCY)); // RL10
  always_ff @(posedge encodeClk) begin
    if (!encodeRstn) begin
      fillCount <= adc_capture_pkg::FILL_RESET;
    end else if (!pipelineFull) begin
      fillCount <= fillCount + 5'h01; // RL10
    end
  end

  // Saturation decode of two's complement codes
  assign posLimit = (padReg == adc_capture_pkg::CODE_FULL_POS); // RL6
  assign negLimit = (padReg == adc_capture_pkg::CODE_FULL_NEG); // RL6

  // One toggle per over-range onset once the pipeline is full; toggling every word could cancel out
  // in pairs between two samples of the slower system clock
  assign ovrOnset = padOvr & ~ovrPrev; // RL7

  // Output word stream, one word per encode cycle
  always_ff @(posedge encodeClk) begin
    if (!encodeRstn) begin
      sample          <= adc_capture_pkg::CODE_ZERO;
      overRange       <= 1'b0;
      sampleValid     <= 1'b0;
      atPositiveLimit <= 1'b0;
      atNegativeLimit <= 1'b0;
      overRangeToggle <= 1'b0;
      ovrPrev         <= 1'b0;
    end else begin
      ovrPrev         <= padOvr;
      sample          <= padReg; // RL6
      overRange       <= padOvr & (posLimit | negLimit); // RL7
      sampleValid     <= pipelineFull; // RL12
      atPositiveLimit <= posLimit;
      atNegativeLimit <= negLimit;
      if (ovrOnset & pipelineFull) begin
        overRangeToggle <= ~overRangeToggle; // RL7
      end
    end
  end
endmodule

// ===== adc_capture_fifo_clocking_sva.sv
// Port checker for the converter capture and FIFO clocking block
`timescale 1ns/10ps
module adc_capture_fifo_clocking_chk (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        encodeClk,
  input wire logic [11:0] padSampleA,
  input wire logic        encodeOutA,
  input wire logic        encodeOutB,
  input wire logic [11:0] sampleA,
  input wire logic [11:0] sampleB,
  input wire logic        overRangeA,
  input wire logic        sampleValidA,
  input wire logic        sampleValidB,
  input wire logic        positiveLimitA,
  input wire logic        negativeLimitB,
  input wire logic        inputFifoClock,
  input wire logic        outputFifoClock,
  input wire logic        inputReturnAligned,
  input wire logic        outputReturnAligned
);
  // FIFO clocks and encode outputs, system domain
  a_fifo_same: assert property (@(posedge clk) disable iff (!rstn)
    inputFifoClock == outputFifoClock) else $error("fifo clocks differ");
  a_fifo_toggle: assert property (@(posedge clk) disable iff (!rstn)
    $past(rstn) |-> inputFifoClock != $past(inputFifoClock)) else $error("fifo clock stuck");
  a_enc_pass: assert property (@(posedge clk) disable iff (!rstn)
    encodeOutA == encodeClk && encodeOutB == encodeClk) else $error("encode out wrong");
  a_ret_aligned: assert property (@(posedge clk) disable iff (!rstn)
    $past(rstn, 6) |-> inputReturnAligned && outputReturnAligned) else $error("return skew");
  // Capture stream, encode domain
  a_pos_code: assert property (@(posedge encodeClk) disable iff (!rstn)
    sampleValidA |-> positiveLimitA == (sampleA == 12'h7FF)) else $error("pos limit wrong");
  a_neg_code: assert property (@(posedge encodeClk) disable iff (!rstn)
    sampleValidB |-> negativeLimitB == (sampleB == 12'h800)) else $error("neg limit wrong");
  a_or_sat: assert property (@(posedge encodeClk) disable iff (!rstn)
    overRangeA |-> sampleA == 12'h7FF || sampleA == 12'h800) else $error("over-range code");
  a_cap_lat: assert property (@(posedge encodeClk) disable iff (!rstn)
    sampleValidA |-> sampleA == $past(padSampleA, 2)) else $error("capture latency");
  a_valid_hold: assert property (@(posedge encodeClk) disable iff (!rstn)
    sampleValidA |=> sampleValidA && sampleValidB) else $error("stream gap");
  c_over: cover property (@(posedge encodeClk) overRangeA);
  c_neg: cover property (@(posedge encodeClk) negativeLimitB);
  c_fill: cover property (@(posedge encodeClk) $rose(sampleValidA));
endmodule
bind adc_capture_fifo_clocking adc_capture_fifo_clocking_chk CHK (.clk, .rstn, .encodeClk,
  .padSampleA, .encodeOutA, .encodeOutB, .sampleA, .sampleB, .overRangeA, .sampleValidA,
  .sampleValidB, .positiveLimitA, .negativeLimitB, .inputFifoClock, .outputFifoClock,
  .inputReturnAligned, .outputReturnAligned);

// ===== adc_far_side.sv
// Far side model: two converters and the carrier FIFO clock buffers
`timescale 1ns/10ps
module adc_far_side (
  input  wire logic   encodeOutA,
  input  wire logic   encodeOutB,
  input  wire logic   inputFifoClock,
  input  wire logic   outputFifoClock,
  input  int          ainA,
  input  int          ainB,
  output logic [11:0] padSampleA = 12'h000,
  output logic [11:0] padSampleB = 12'h000,
  output logic        padOverRangeA = 1'b0,
  output logic        padOverRangeB = 1'b0,
  output logic        inputFifoClockReturn = 1'b0,
  output logic        outputFifoClockReturn = 1'b0
);
  // Saturating two's complement code plus flag
  function automatic logic [12:0] convert(int v);
    if (v > 2047) return {1'b1, 12'h7FF};
    if (v < -2048) return {1'b1, 12'h800};
    return {1'b0, v[11:0]};
  endfunction
  // Converter outputs change after each encode rise
  always @(posedge encodeOutA) {padOverRangeA, padSampleA} <= convert(ainA);
  always @(posedge encodeOutB) {padOverRangeB, padSampleB} <= convert(ainB);
  // Buffered clocks come back with small delay
  always @(inputFifoClock) inputFifoClockReturn <= #2 inputFifoClock;
  always @(outputFifoClock) outputFifoClockReturn <= #2 outputFifoClock;
endmodule

// ===== adc_capture_fifo_clocking_tb.sv
// Self-checking bench for the converter capture and FIFO clocking block
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module adc_capture_fifo_clocking_tb;
  logic clk = 0, rstn = 0, encodeClk = 0, clearOverRange = 0;
  logic [11:0] padSampleA, padSampleB, sampleA, sampleB;
  logic padOverRangeA, padOverRangeB, encodeOutA, encodeOutB, overRangeA, overRangeB;
  logic sampleValidA, sampleValidB, positiveLimitA, negativeLimitA, positiveLimitB;
  logic negativeLimitB, inputFifoClock, outputFifoClock, inputFifoClockReturn;
  logic outputFifoClockReturn, inputReturnAligned, outputReturnAligned;
  logic overRangeSeenA, overRangeSeenB;
  logic [25:0] q[$];
  logic [25:0] e;
  int ainA = 0, ainB = 0, n_fail = 0, cmp_count = 0, seed = 32'hcbe1c8c5;
  int tbl[6] = '{0, 2047, 2048, -2048, -2049, -1};
  adc_capture_fifo_clocking DUT (.clk, .rstn, .encodeClk, .padSampleA, .padOverRangeA,
    .padSampleB, .padOverRangeB, .encodeOutA, .encodeOutB, .sampleA, .overRangeA,
    .sampleValidA, .sampleB, .overRangeB, .sampleValidB, .positiveLimitA, .negativeLimitA,
    .positiveLimitB, .negativeLimitB, .inputFifoClock, .outputFifoClock,
    .inputFifoClockReturn, .outputFifoClockReturn, .inputReturnAligned,
    .outputReturnAligned, .clearOverRange, .overRangeSeenA, .overRangeSeenB);
  adc_far_side FAR (.encodeOutA, .encodeOutB, .inputFifoClock, .outputFifoClock, .ainA,
    .ainB, .padSampleA, .padSampleB, .padOverRangeA, .padOverRangeB,
    .inputFifoClockReturn, .outputFifoClockReturn);
  // 10 MHz system clock, 48 ns encode clock in its own phase
  initial forever #50 clk = ~clk;
  initial begin #7; forever #24 encodeClk = ~encodeClk; end
  // Reference model: word pushed at one encode rise shows after the next
  always @(posedge encodeClk) begin
    q.push_back({padOverRangeB, padSampleB, padOverRangeA, padSampleA});
    if (q.size() > 2) void'(q.pop_front());
  end
  always @(negedge encodeClk) if (rstn && q.size() == 2 && sampleValidA === 1'b1) begin
    e = q[0];
    `CHK(sampleA, e[11:0])
    `CHK(sampleB, e[24:13])
    `CHK(overRangeA, e[12] && (e[11:0] == 12'h7FF || e[11:0] == 12'h800))
    `CHK(overRangeB, e[25] && (e[24:13] == 12'h7FF || e[24:13] == 12'h800))
    `CHK({positiveLimitA, negativeLimitA}, {e[11:0] == 12'h7FF, e[11:0] == 12'h800})
    `CHK({positiveLimitB, negativeLimitB}, {e[24:13] == 12'h7FF, e[24:13] == 12'h800})
    `CHK(sampleValidB, 1'b1)
  end
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Main sequence: fill, random stream, boundary codes, sticky flag
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1;
    for (int i = 0; i < 40 && sampleValidA !== 1'b1; i++) @(posedge clk);
    `CHK(sampleValidA, 1'b1)
    if (sampleValidA !== 1'b1) final_report();
    repeat (300) begin
      @(posedge clk);
      ainA <= $random(seed) % 2300;
      ainB <= $random(seed) % 2300;
    end
    $display("test random stream done");
    foreach (tbl[i]) begin
      @(posedge clk);
      ainA <= tbl[i];
      ainB <= -tbl[i];
      repeat (3) @(posedge clk);
    end
    $display("test boundary codes done");
    repeat (4) @(posedge clk);
    #1 `CHK({overRangeSeenA, overRangeSeenB}, 2'b11)
    `CHK({inputReturnAligned, outputReturnAligned}, 2'b11)
    @(posedge clk) clearOverRange <= 1;
    repeat (2) @(posedge clk);
    clearOverRange <= 0;
    repeat (2) @(posedge clk);
    #1 `CHK({overRangeSeenA, overRangeSeenB}, 2'b00)
    $display("test sticky flag done");
    final_report();
  end
endmodule
